// >>> design/dgd_core.sv
// Dual-channel gate drive interlock core with a classic Wishbone register slave.
//
// Overview of operation
// R1: Primary undervoltage forces both gates off and pulls both fault flags low.
// R2: After primary supply recovers, lockout holds for the blocking interval, then releases.
// R3: Primary blocking count starts only once primary undervoltage has cleared.
// R4: Secondary undervoltage turns its channel off, holds it, asserts its flag at once.
// R5: Secondary blocking count starts at the moment the fault is detected.
// R6: A new fault during a running blocking interval restarts the count.
// R7: Mode resistor of zero selects direct mode; nonzero selects half-bridge mode.
// R8: Direct mode: each channel follows its own input, high on, low off.
// R9: Direct mode applies no interlock; the host must insert dead time itself.
// R10: Half-bridge mode: input A is the PWM command, input B the common enable.
// R11: Half-bridge mode: enable low holds both channels off, high lets PWM control.
// R12: PWM rising edge: channel 2 off at once, channel 1 on after dead time.
// R13: PWM falling edge: channel 1 off at once, channel 2 on after dead time.
// R14: Dead time follows the mode resistor; the nominal setting gives 3.0 us.
// R15: Fault flags are open drain: released without fault, pulled low with fault.
// R16: The host may join both flags but is advised to watch them apart.
// R17: Blocking interval in ms equals block time resistor in kohm minus 55, 20 to 130 ms.
// R18: Block time resistor of zero gives a fixed 10 us blocking interval.
// R19: On drive pulls up and off drive pulls down, never both enabled at once.
// R20: A PWM edge inside the dead time cancels the pending turn-on and restarts it.
// R21: A secondary fault disables only its own channel and asserts only its flag.
//
// Our own choices: register access over Wishbone and the placing of the registers.

`include "dgd_params.svh"

`timescale 1ns/10ps
`default_nettype none

module dgd_core
  import dgd_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = `DGD_MS_NS / `DGD_CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic input_a_i,
  input wire logic input_b_i,
  input wire logic primary_uv_i,
  input wire logic [1:0] secondary_uv_i,
  output logic [1:0] gate_on_drive_o,
  output logic [1:0] gate_off_drive_o,
  input wire logic fault_flag_a_i,
  output logic fault_flag_a_o,
  output logic fault_flag_a_oe_n_o,
  input wire logic fault_flag_b_i,
  output logic fault_flag_b_o,
  output logic fault_flag_b_oe_n_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Resistors outside the supported window are clamped, since the
  // interval would be unstable there anyway.
  function automatic logic [31:0] blk_cycles(input logic [7:0] res);
    logic [31:0] r;
    r = 32'(res);
    if (res == 8'h00) begin
      return 32'(`DGD_TB_SHORT_CYC); // R18
    end
    if (r < 32'(`DGD_TB_MIN_KOHM)) begin
      r = 32'(`DGD_TB_MIN_KOHM);
    end
    if (r > 32'(`DGD_TB_MAX_KOHM)) begin
      r = 32'(`DGD_TB_MAX_KOHM);
    end
    return 32'((r - 32'(`DGD_TB_OFFSET_KOHM)) * CYC_PER_MS); // R17
  endfunction

  function automatic logic [8:0] dead_cycles(input logic [7:0] res);
    return 9'(32'(res) * 32'(`DGD_DT_CYC_PER_KOHM)); // R14
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dgd_state_t s_q;
  dgd_state_t s_d;

  logic req;
  logic half_bridge;
  logic pri_lock;
  logic [1:0] cmd;
  logic [1:0] sec_rise;
  logic [1:0] sec_blk;
  logic [31:0] status;
  logic [31:0] blk_load;
  logic [8:0] dt_load;

  assign req = wb_cyc_i & wb_stb_i;
  assign half_bridge = (s_q.mode_res != 8'h00); // R7
  assign blk_load = blk_cycles(s_q.blk_res);
  assign dt_load = dead_cycles(s_q.mode_res);

  always_comb begin
    status = 32'h0;
    status[`DGD_ST_GATE_LSB +: 2] = s_q.gate_on;
    status[`DGD_ST_PULL_LSB +: 2] = s_q.flag_pull;
    status[`DGD_ST_PRI_LOCK] = (s_q.pri_st != PRI_RUN);
    status[`DGD_ST_SEC_LSB +: 2] = sec_blk;
    status[`DGD_ST_LINE_LSB] = fault_flag_a_i;
    status[`DGD_ST_LINE_LSB + 1] = fault_flag_b_i;
    status[`DGD_ST_HALF_BRIDGE] = half_bridge;
  end

  always_comb begin
    sec_blk = 2'b00;
    for (int c = 0; c < 2; c++) begin
      sec_blk[c] = secondary_uv_i[c] | (s_q.sec_cnt[c] != 32'h0);
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    sec_rise = 2'b00;
    cmd = 2'b00;
    pri_lock = 1'b1;

    // Register slave: the answer comes one cycle after the request is
    // seen, and a write lands on the edge that samples the answer.
    s_d.ack = req & ~s_q.ack;
    if (req & ~s_q.ack & ~wb_we_i) begin
      case (wb_adr_i)
        `DGD_ADDR_MODE_RES: begin
          s_d.dat = {24'h0, s_q.mode_res};
        end
        `DGD_ADDR_BLK_RES: begin
          s_d.dat = {24'h0, s_q.blk_res};
        end
        `DGD_ADDR_STATUS: begin
          s_d.dat = status;
        end
        default: begin
          s_d.dat = 32'h0;
        end
      endcase
    end
    if (req & s_q.ack & wb_we_i & wb_sel_i[0]) begin
      case (wb_adr_i)
        `DGD_ADDR_MODE_RES: begin
          s_d.mode_res = wb_dat_i[7:0];
        end
        `DGD_ADDR_BLK_RES: begin
          s_d.blk_res = wb_dat_i[7:0];
        end
        default: begin
        end
      endcase
    end

    // Primary supply lockout.
    case (s_q.pri_st)
      PRI_RUN: begin
        if (primary_uv_i) begin
          s_d.pri_st = PRI_UV; // R1
        end
      end
      PRI_UV: begin
        if (!primary_uv_i) begin
          s_d.pri_st = PRI_BLOCK; // R3
          s_d.pri_cnt = blk_load;
        end
      end
      PRI_BLOCK: begin
        if (primary_uv_i) begin
          s_d.pri_st = PRI_UV; // R6
        end else if (s_q.pri_cnt <= 32'h1) begin
          s_d.pri_st = PRI_RUN; // R2
          s_d.pri_cnt = 32'h0;
        end else begin
          s_d.pri_cnt = s_q.pri_cnt - 32'h1;
        end
      end
      default: begin
        s_d.pri_st = PRI_UV;
      end
    endcase
    pri_lock = (s_d.pri_st != PRI_RUN);

    // Secondary supply lockout, one independent counter per channel.
    for (int c = 0; c < 2; c++) begin
      sec_rise[c] = secondary_uv_i[c] & ~s_q.sec_uv_prev[c];
      s_d.sec_uv_prev[c] = secondary_uv_i[c];
      if (sec_rise[c]) begin
        s_d.sec_cnt[c] = blk_load; // R5 R6
      end else if (s_q.sec_cnt[c] != 32'h0) begin
        s_d.sec_cnt[c] = s_q.sec_cnt[c] - 32'h1;
      end
    end

    // Half-bridge translation with dead time.
    s_d.pwm_prev = input_a_i;
    if (!input_b_i) begin
      // Loading here means an enable always opens with a full dead time.
      s_d.hb_on = 2'b00; // R11
      s_d.hb_tgt = ~input_a_i;
      s_d.dt_cnt = dt_load;
    end else if (input_a_i != s_q.pwm_prev) begin
      s_d.hb_on = 2'b00; // R12 R13
      s_d.hb_tgt = ~input_a_i;
      s_d.dt_cnt = dt_load; // R20
    end else if (s_q.dt_cnt != 9'h0) begin
      s_d.dt_cnt = s_q.dt_cnt - 9'h1;
      if (s_q.dt_cnt == 9'h1) begin
        s_d.hb_on[s_q.hb_tgt] = 1'b1; // R12 R13
      end
    end

    if (half_bridge) begin
      cmd = s_d.hb_on; // R10
    end else begin
      cmd = {input_b_i, input_a_i}; // R8
    end

    for (int c = 0; c < 2; c++) begin
      s_d.gate_on[c] = cmd[c] & ~pri_lock &
        ~(secondary_uv_i[c] | sec_rise[c] | (s_d.sec_cnt[c] != 32'h0)); // R1 R4 R21
      s_d.flag_pull[c] = pri_lock | secondary_uv_i[c] |
        (s_d.sec_cnt[c] != 32'h0); // R1 R4 R21
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.pri_st <= PRI_UV;
      s_q.pri_cnt <= 32'h0;
      s_q.sec_cnt <= '0;
      s_q.sec_uv_prev <= 2'b00;
      s_q.pwm_prev <= 1'b0;
      s_q.dt_cnt <= 9'h0;
      s_q.hb_tgt <= 1'b0;
      s_q.hb_on <= 2'b00;
      s_q.gate_on <= 2'b00;
      s_q.flag_pull <= 2'b11;
      s_q.mode_res <= `DGD_MODE_RES_RST;
      s_q.blk_res <= `DGD_BLK_RES_RST;
      s_q.ack <= 1'b0;
      s_q.dat <= 32'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;

  // Both switches derive from one flop, so they can never overlap.
  assign gate_on_drive_o = s_q.gate_on; // R19
  assign gate_off_drive_o = ~s_q.gate_on; // R19

  // The drain transistor only ever pulls low; the pull-up lives outside.
  assign fault_flag_a_o = 1'b0; // R15
  assign fault_flag_a_oe_n_o = ~s_q.flag_pull[0]; // R15
  assign fault_flag_b_o = 1'b0; // R15
  assign fault_flag_b_oe_n_o = ~s_q.flag_pull[1]; // R15

endmodule

`default_nettype wire

// >>> design/dgd_params.svh
// Offsets, field positions, reset values and timing constants of the gate drive interlock.
`ifndef DGD_PARAMS_SVH
`define DGD_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DGD_ADDR_MODE_RES 8'h00
`define DGD_ADDR_BLK_RES 8'h04
`define DGD_ADDR_STATUS 8'h08

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DGD_MODE_RES_RST 8'h00
`define DGD_BLK_RES_RST 8'h96

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define DGD_ST_GATE_LSB 0
`define DGD_ST_PULL_LSB 2
`define DGD_ST_PRI_LOCK 4
`define DGD_ST_SEC_LSB 5
`define DGD_ST_LINE_LSB 7
`define DGD_ST_HALF_BRIDGE 9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DGD_CLK_NS 10
`define DGD_MS_NS 1000000
`define DGD_TB_SHORT_NS 10000
`define DGD_TB_SHORT_CYC (`DGD_TB_SHORT_NS / `DGD_CLK_NS)
`define DGD_TB_OFFSET_KOHM 55
`define DGD_TB_MIN_KOHM 75
`define DGD_TB_MAX_KOHM 185
`define DGD_DT_NS_PER_KOHM 20
`define DGD_DT_CYC_PER_KOHM (`DGD_DT_NS_PER_KOHM / `DGD_CLK_NS)

`endif

// >>> design/dgd_pkg.sv
// Types shared by the gate drive interlock logic.
`default_nettype none
package dgd_pkg;

  // ----------------------------------------------------------------
  // Primary supply lockout states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PRI_RUN = 3'b001,
    PRI_UV = 3'b010,
    PRI_BLOCK = 3'b100
  } dgd_pri_st_t;

  // ----------------------------------------------------------------
  // Whole state of the core
  // ----------------------------------------------------------------
  typedef struct packed {
    dgd_pri_st_t pri_st;
    logic [31:0] pri_cnt;
    logic [1:0][31:0] sec_cnt;
    logic [1:0] sec_uv_prev;
    logic pwm_prev;
    logic [8:0] dt_cnt;
    logic hb_tgt;
    logic [1:0] hb_on;
    logic [1:0] gate_on;
    logic [1:0] flag_pull;
    logic [7:0] mode_res;
    logic [7:0] blk_res;
    logic ack;
    logic [31:0] dat;
  } dgd_state_t;

endpackage
`default_nettype wire

// >>> test/dgd_core_sva.sv
// Port assertions for the gate drive interlock core.
`timescale 1ns/10ps
`default_nettype none
module dgd_core_sva #(
  parameter int unsigned CYC_PER_MS = 100000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic primary_uv_i,
  input wire logic [1:0] secondary_uv_i,
  input wire logic [1:0] gate_on_drive_o,
  input wire logic [1:0] gate_off_drive_o,
  input wire logic fault_flag_a_o,
  input wire logic fault_flag_a_oe_n_o,
  input wire logic fault_flag_b_oe_n_o
);
  // The shortest legal lockout; the strap value itself is not visible at the ports.
  localparam int unsigned MIN_BLK = (20 * CYC_PER_MS < 1000) ? 20 * CYC_PER_MS : 1000;
  logic [31:0] clr_cnt_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || primary_uv_i) begin
      clr_cnt_q <= 32'h0;
    end else if (clr_cnt_q != 32'hffffffff) begin
      clr_cnt_q <= clr_cnt_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_locked;
    gate_on_drive_o == 2'h0 && !fault_flag_a_oe_n_o && !fault_flag_b_oe_n_o;
  endsequence
  property p_pull_excl;
    gate_off_drive_o == ~gate_on_drive_o;
  endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("drives overlap");
  property p_open_drain;
    fault_flag_a_o == 1'h0;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("flag driven high");
  property p_pri_lock;
    primary_uv_i |=> s_locked;
  endproperty
  a_pri_lock: assert property (p_pri_lock) else $error("no primary lockout");
  property p_pri_hold;
    $fell(primary_uv_i) |-> s_locked [*8];
  endproperty
  a_pri_hold: assert property (p_pri_hold) else $error("lockout dropped on clear");
  property p_pri_rel;
    $rose(fault_flag_a_oe_n_o) |-> clr_cnt_q >= MIN_BLK - 2;
  endproperty
  a_pri_rel: assert property (p_pri_rel) else $error("flag released early");
  property p_sec_b;
    $rose(secondary_uv_i[1]) |=> !gate_on_drive_o[1] && !fault_flag_b_oe_n_o;
  endproperty
  a_sec_b: assert property (p_sec_b) else $error("channel fault not taken");
  property p_sec_iso;
    $rose(secondary_uv_i[1]) && !secondary_uv_i[0] && !primary_uv_i && fault_flag_a_oe_n_o
      |=> fault_flag_a_oe_n_o;
  endproperty
  a_sec_iso: assert property (p_sec_iso) else $error("fault spread to other channel");
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("bus not answered");
endmodule
bind dgd_core dgd_core_sva #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.*);
`default_nettype wire

// >>> test/dgd_host_model.sv
// Host side of the fault flags: pulled-up open-drain lines.
`timescale 1ns/10ps
`default_nettype none
module dgd_host_model (
  input wire logic flag_a_oe_n_i,
  input wire logic flag_a_i,
  input wire logic flag_b_oe_n_i,
  input wire logic flag_b_i,
  output logic line_a_o,
  output logic line_b_o
);
  // Each line keeps its own pull-up so a fault is traced to its channel.
  assign line_a_o = flag_a_oe_n_i ? 1'h1 : flag_a_i;
  assign line_b_o = flag_b_oe_n_i ? 1'h1 : flag_b_i;
endmodule
`default_nettype wire

// >>> test/dgd_core_tb.sv
// Self-checking bench for the gate drive interlock core.
`include "dgd_params.svh"
`timescale 1ns/10ps
`default_nettype none
module dgd_core_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, input_a_i, input_b_i, primary_uv_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0] secondary_uv_i, gate_on_drive_o, gate_off_drive_o;
  logic fault_flag_a_i, fault_flag_a_o, fault_flag_a_oe_n_o;
  logic fault_flag_b_i, fault_flag_b_o, fault_flag_b_oe_n_o;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // Direct mode rows: input a, input b, expected gate pair.
  logic [3:0] rows [5] = '{4'h0, 4'h9, 4'h0, 4'h6, 4'h0};
  dgd_core #(.CYC_PER_MS(10)) dut_u (.*);
  dgd_host_model host_u (.flag_a_oe_n_i(fault_flag_a_oe_n_o), .flag_a_i(fault_flag_a_o),
    .flag_b_oe_n_i(fault_flag_b_oe_n_o), .flag_b_i(fault_flag_b_o),
    .line_a_o(fault_flag_a_i), .line_b_o(fault_flag_b_i));
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic g(input logic [3:0] e);
    chk({28'h0, gate_on_drive_o, fault_flag_b_i, fault_flag_a_i}, {28'h0, e});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic drv(input logic a, input logic b);
    @(posedge clk_i);
    input_a_i <= a;
    input_b_i <= b;
  endtask
  task automatic fault(input logic p, input logic [1:0] s);
    @(posedge clk_i);
    primary_uv_i <= p;
    secondary_uv_i <= s;
  endtask
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_sel_i <= 4'h1;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    chk({31'h0, n < 20}, 32'h1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // The whole sequence needs about 4100 cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, input_a_i, input_b_i, primary_uv_i} = 7'h40;
    {wb_adr_i, wb_dat_i, secondary_uv_i} = 42'h0;
    wb_sel_i = 4'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    step(1);
    g(4'h0);
    bus(1'h0, 8'h0c, 32'h0);
    chk(rd, 32'h0);
    bus(1'h0, `DGD_ADDR_STATUS, 32'h0);
    chk(rd & 32'h200, 32'h0);
    step(1100);
    g(4'h3);
    foreach (rows[i]) begin
      drv(rows[i][3], rows[i][2]);
      step(2);
      g({rows[i][1:0], 2'h3});
    end
    bus(1'h1, `DGD_ADDR_MODE_RES, 32'h96);
    bus(1'h0, `DGD_ADDR_STATUS, 32'h0);
    chk(rd & 32'h200, 32'h200);
    drv(1'h0, 1'h1);
    step(302);
    g(4'hb);
    drv(1'h1, 1'h1);
    step(1);
    g(4'h3);
    step(299);
    g(4'h3);
    step(1);
    g(4'h7);
    drv(1'h0, 1'h1);
    step(1);
    g(4'h3);
    drv(1'h1, 1'h1);
    step(300);
    g(4'h3);
    step(1);
    g(4'h7);
    drv(1'h1, 1'h0);
    step(1);
    g(4'h3);
    drv(1'h0, 1'h1);
    step(300);
    g(4'h3);
    step(1);
    g(4'hb);
    bus(1'h1, `DGD_ADDR_BLK_RES, 32'h0);
    fault(1'h0, 2'h2);
    step(1);
    g(4'h1);
    fault(1'h0, 2'h0);
    step(500);
    fault(1'h0, 2'h2);
    step(300);
    g(4'h1);
    fault(1'h0, 2'h0);
    step(690);
    g(4'h1);
    step(20);
    chk({31'h0, fault_flag_b_i}, 32'h1);
    bus(1'h1, `DGD_ADDR_BLK_RES, 32'h4b);
    fault(1'h1, 2'h0);
    step(50);
    g(4'h0);
    fault(1'h0, 2'h0);
    step(190);
    g(4'h0);
    step(20);
    chk({30'h0, fault_flag_b_i, fault_flag_a_i}, 32'h3);
    test_done();
  end
endmodule
`default_nettype wire
